// ==== rtl/ats_pkg.sv ====
/*
  shared constants and types for the acquisition and trigger sequencer:
  register map, field positions, reset values, encodings, timing.
  assumes a 20 MHz core clock and a 32-bit apb register bus.
*/
`default_nettype none
package ats_pkg;
  // register byte offsets
  localparam logic [7:0] ATS_OFF_CTRL   = 8'h00;
  localparam logic [7:0] ATS_OFF_RECORD = 8'h04;
  localparam logic [7:0] ATS_OFF_TRIG   = 8'h08;
  localparam logic [7:0] ATS_OFF_DELAY  = 8'h0C;
  localparam logic [7:0] ATS_OFF_WINDOW = 8'h10;
  localparam logic [7:0] ATS_OFF_CMD    = 8'h14;
  localparam logic [7:0] ATS_OFF_STATUS = 8'h18;
  // control register fields
  localparam int ATS_CTRL_SAF   = 0;  // stop_after_fill
  localparam int ATS_CTRL_MULTI = 1;  // multi-record mode
  localparam int ATS_CTRL_AUTO  = 2;  // trigger_qualify_mode, 1 = auto
  localparam int ATS_CTRL_EXTARM = 3; // external arming
  localparam int ATS_CTRL_GEOM  = 4;  // geometry correction enable
  // command register fields (write-one pulses)
  localparam int ATS_CMD_STATE_LO = 0; // record state command [1:0]
  localparam int ATS_CMD_STATE_V  = 2; // state command valid
  localparam int ATS_CMD_TRIG     = 3; // host trigger
  localparam int ATS_CMD_MAP      = 4; // distortion-mapping run
  // record register fields
  localparam int ATS_REC_CNT_LO = 0;   // record_count_cmd [4:0]
  localparam int ATS_REC_STA_LO = 8;   // start record index [11:8]
  // host state command values
  localparam logic [1:0] ATS_CMD_STOP          = 2'h0;
  localparam logic [1:0] ATS_CMD_RUN           = 2'h1;
  localparam logic [1:0] ATS_CMD_RUN_THEN_HALT = 2'h2;
  // reported acquisition state
  localparam logic [1:0] ATS_RPT_STOPPED  = 2'h0;
  localparam logic [1:0] ATS_RPT_RUNNING  = 2'h1;
  localparam logic [1:0] ATS_RPT_RUN_HALT = 2'h2;
  // record limits
  localparam logic [4:0] ATS_REC_MIN = 5'h01;
  localparam logic [4:0] ATS_REC_MAX = 5'h10;
  localparam logic [3:0] ATS_PTR_LAST = 4'hF;
  // trigger sources, dual-channel variant / calibrator variant
  localparam logic [1:0] ATS_SRC_CH1 = 2'h0;
  localparam logic [1:0] ATS_SRC_CH2 = 2'h1;
  localparam logic [1:0] ATS_SRC_SUM = 2'h2;
  localparam logic [1:0] ATS_SRC_EXT = 2'h3;
  localparam logic [1:0] ATS_SRC_CAL = 2'h0;
  // coupling encoding
  localparam logic ATS_COUP_AC = 1'b0;
  localparam logic ATS_COUP_DC = 1'b1;
  // delay as a fraction of the window, in 1/1024 units, up to 5 windows
  localparam int          ATS_DLY_SHIFT = 10;
  localparam logic [12:0] ATS_DLY_MAX   = 13'h1400;
  // timing
  localparam longint ATS_CLK_HZ        = 20_000_000;
  localparam longint ATS_AUTO_WAIT_MS  = 360;
  localparam longint ATS_AUTO_WAIT_CYC = ATS_AUTO_WAIT_MS * ATS_CLK_HZ / 1000;
  localparam logic [31:0] ATS_WINDOW_RST = 32'h0000_0014; // 1 us
  // trigger configuration carrier
  typedef struct packed {
    logic signed [15:0] threshold; // trigger_threshold
    logic               pct_units; // level in percent of full scale
    logic               coupling;  // trigger_coupling_sel
    logic               falling;   // slope select
    logic [1:0]         source;    // source select
  } ats_trig_cfg_s;
  localparam int ATS_TRIG_W = 21;
  // sequencer states
  typedef enum logic [3:0] {
    ATS_ST_IDLE  = 4'b0001,
    ATS_ST_ARMED = 4'b0010,
    ATS_ST_DELAY = 4'b0100,
    ATS_ST_STORE = 4'b1000
  } ats_state_e;
endpackage : ats_pkg
`default_nettype wire

// ==== rtl/ats_sequencer.sv ====
/*
  acquisition and trigger sequencer with apb register slave.
  assumes comparator outputs and operator pulses are synchronous to
  core_clk_in, and that the capture engine pulses capture_done_in once
  per filled record after store_start_out.
*/
// The register offsets and the APB register port were chosen for this implementation.
// Behaviour
// - record count accepted from one to sixteen
// - after record sixteen continue at one
// - keep filling ascending until count reached
// - stop-after-fill halts after last record
// - triggers ignored once required records filled
// - without stop-after-fill acquire until stopped
// - report running, running-halt or stopped
// - hold geometry-correction enable for processing
// - mapping run acquires series, reports running (running-halt if stop-after-fill set)
// - auto mode self-triggers after 360 ms
// - normal mode: event, button or host
// - slope selectable rising or falling
// - inverted channel inverts signal only
// - source selection per model variant
// - signed threshold in volts or percent
// - external source forces ac coupling
// - storage delay up to five windows
// - delay kept as fraction of window
// - external arm blocks trigger unless low
// - arm input ignored internal or auto
`default_nettype none
module ats_sequencer
  import ats_pkg::*;
#(
  parameter int unsigned AUTO_TIMEOUT_CYC = 32'(ATS_AUTO_WAIT_CYC),
  parameter bit          DUAL_CHANNEL     = 1'b1,
  parameter int unsigned MAP_ACQS         = 8
)(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // trigger comparator path
  input  wire logic        channel_one_input_in,
  input  wire logic        channel_two_input_in,
  input  wire logic        channel_sum_in,
  input  wire logic        ext_trig_in,
  input  wire logic        calib_in,
  input  wire logic        ch_invert_in,
  input  wire logic        ext_arm_n_in,
  output ats_trig_cfg_s    trig_cfg_out,
  // operator controls
  input  wire logic        man_trig_in,
  input  wire logic        man_stop_in,
  // capture engine
  input  wire logic        capture_done_in,
  output logic             store_start_out,
  output logic      [3:0]  record_ptr_out,
  output logic             geom_correct_out,
  output logic             map_active_out,
  output logic      [1:0]  acq_state_out
);

  ats_state_e     st;            // sequencer state
  logic           stop_after_fill;
  logic           multi_mode;
  logic           auto_mode;     // trigger_qualify_mode
  logic           ext_arm_sel;
  logic           geom_en;
  logic [4:0]     rec_count;     // record_count_cmd
  logic [3:0]     start_rec;     // zero-based start record
  ats_trig_cfg_s  trig_cfg;
  logic [12:0]    post_trigger_delay; // window fraction, 1/1024
  logic [31:0]    window_cyc;    // time window in clock cycles
  logic [4:0]     remaining;     // records still to fill
  logic [3:0]     rec_ptr;       // current record, zero based
  logic [31:0]    auto_cnt;      // auto-trigger timeout counter
  logic [31:0]    dly_cnt;       // storage delay counter
  logic           map_active;
  logic           trig_q;        // previous selected trigger level
  logic           trig_sig;      // selected, inverted trigger level
  logic           trig_edge;
  logic           arm_ok;
  logic           auto_fire;
  logic           trig_accept;
  logic [44:0]    dly_prod;
  logic [31:0]    dly_target;
  logic           wr_en;
  logic           rd_en;
  logic           addr_hit;
  logic           cmd_state_v;
  logic [1:0]     cmd_state;
  logic           host_trig;
  logic           map_req;
  logic           start_req;
  logic           stop_req;
  logic           last_rec;
  logic [4:0]     wr_count;

  // apb decode: writes act in the access cycle, zero wait states
  assign wr_en = psel_in & penable_in & pwrite_in;
  assign rd_en = psel_in & ~penable_in & ~pwrite_in;
  assign pready_out = 1'b1;
  always_comb
  begin
    case (paddr_in)
      ATS_OFF_CTRL, ATS_OFF_RECORD, ATS_OFF_TRIG, ATS_OFF_DELAY,
      ATS_OFF_WINDOW, ATS_OFF_CMD, ATS_OFF_STATUS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end
  assign pslverr_out = psel_in & penable_in & ~addr_hit;

  // command strobes from the command register
  assign cmd_state_v = wr_en & (paddr_in == ATS_OFF_CMD)
                       & pwdata_in[ATS_CMD_STATE_V];
  assign cmd_state   = pwdata_in[ATS_CMD_STATE_LO +: 2];
  assign host_trig   = wr_en & (paddr_in == ATS_OFF_CMD)
                       & pwdata_in[ATS_CMD_TRIG];
  assign map_req     = wr_en & (paddr_in == ATS_OFF_CMD)
                       & pwdata_in[ATS_CMD_MAP];
  assign start_req   = (cmd_state_v & (cmd_state != ATS_CMD_STOP)) | map_req;
  assign stop_req    = (cmd_state_v & (cmd_state == ATS_CMD_STOP))
                       | man_stop_in;
  assign wr_count    = pwdata_in[ATS_REC_CNT_LO +: 5];

  // control register and stop-after-fill state
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      stop_after_fill <= 1'b0;
      multi_mode      <= 1'b0;
      auto_mode       <= 1'b1;
      ext_arm_sel     <= 1'b0;
      geom_en         <= 1'b0;
    end
    else if (wr_en && paddr_in == ATS_OFF_CTRL)
    begin
      stop_after_fill <= pwdata_in[ATS_CTRL_SAF];
      multi_mode      <= pwdata_in[ATS_CTRL_MULTI];
      auto_mode       <= pwdata_in[ATS_CTRL_AUTO];
      ext_arm_sel     <= pwdata_in[ATS_CTRL_EXTARM];
      geom_en         <= pwdata_in[ATS_CTRL_GEOM];
    end
    else if (cmd_state_v && cmd_state != ATS_CMD_STOP)
    begin
      // run_then_halt turns stop-after-fill on, plain run turns it off
      stop_after_fill <= (cmd_state == ATS_CMD_RUN_THEN_HALT);
    end
  end

  // record register: out-of-range counts are ignored
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rec_count <= ATS_REC_MIN;
      start_rec <= 4'h0;
    end
    else if (wr_en && paddr_in == ATS_OFF_RECORD)
    begin
      if (wr_count >= ATS_REC_MIN && wr_count <= ATS_REC_MAX)
      begin
        rec_count <= wr_count;
      end
      start_rec <= pwdata_in[ATS_REC_STA_LO +: 4];
    end
  end

  // trigger, delay and window registers
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      trig_cfg           <= '0;
      post_trigger_delay <= 13'h0000;
      window_cyc         <= ATS_WINDOW_RST;
    end
    else if (wr_en)
    begin
      if (paddr_in == ATS_OFF_TRIG)
      begin
        trig_cfg <= ats_trig_cfg_s'(pwdata_in[ATS_TRIG_W-1:0]);
      end
      if (paddr_in == ATS_OFF_DELAY)
      begin
        // clamp to five windows
        post_trigger_delay <= (pwdata_in[12:0] > ATS_DLY_MAX) ?
                              ATS_DLY_MAX : pwdata_in[12:0];
      end
      if (paddr_in == ATS_OFF_WINDOW)
      begin
        window_cyc <= pwdata_in;
      end
    end
  end

  // outgoing trigger configuration, coupling and units forced for ext
  always_comb
  begin
    trig_cfg_out = trig_cfg;
    if (DUAL_CHANNEL && trig_cfg.source == ATS_SRC_EXT)
    begin
      trig_cfg_out.coupling  = ATS_COUP_AC;
      trig_cfg_out.pct_units = 1'b0;
    end
    else if (!DUAL_CHANNEL)
    begin
      trig_cfg_out.coupling = ATS_COUP_AC;
      if (trig_cfg.source != ATS_SRC_CAL)
      begin
        trig_cfg_out.pct_units = 1'b0;
      end
    end
  end

  // source select; inversion only on internal channels
  always_comb
  begin
    trig_sig = ext_trig_in;
    if (DUAL_CHANNEL)
    begin
      case (trig_cfg.source)
        ATS_SRC_CH1: trig_sig = channel_one_input_in ^ ch_invert_in;
        ATS_SRC_CH2: trig_sig = channel_two_input_in ^ ch_invert_in;
        ATS_SRC_SUM: trig_sig = channel_sum_in ^ ch_invert_in;
        default:     trig_sig = ext_trig_in;
      endcase
    end
    else if (trig_cfg.source == ATS_SRC_CAL)
    begin
      trig_sig = calib_in;
    end
  end

  // edge of the selected signal per slope choice
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      trig_q <= 1'b0;
    else
      trig_q <= trig_sig;
  end
  assign trig_edge = trig_cfg.falling ? (trig_q & ~trig_sig)
                                      : (~trig_q & trig_sig);

  // arming, qualification and auto timeout
  assign arm_ok = auto_mode | ~ext_arm_sel | ~ext_arm_n_in;
  assign auto_fire = auto_mode
                     & (auto_cnt == AUTO_TIMEOUT_CYC - 32'h0000_0001);
  assign trig_accept = (st == ATS_ST_ARMED)
                       & ((arm_ok & (trig_edge | man_trig_in
                          | host_trig)) | auto_fire);

  // timeout counter runs only while armed
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      auto_cnt <= 32'h0000_0000;
    else if (st != ATS_ST_ARMED || trig_accept || start_req)
      auto_cnt <= 32'h0000_0000;
    else
      auto_cnt <= auto_cnt + 32'h0000_0001;
  end

  // delay target follows the current window
  assign dly_prod   = window_cyc * post_trigger_delay;
  assign dly_target = dly_prod[ATS_DLY_SHIFT +: 32];
  assign last_rec   = (remaining == ATS_REC_MIN);

  // sequencer state, record pointer and remaining count
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st         <= ATS_ST_IDLE;
      remaining  <= ATS_REC_MIN;
      rec_ptr    <= 4'h0;
      dly_cnt    <= 32'h0000_0000;
      map_active <= 1'b0;
    end
    else if (start_req)
    begin
      // newly initiated: reload counters
      st         <= ATS_ST_ARMED;
      map_active <= map_req;
      remaining  <= map_req ? 5'(MAP_ACQS)
                  : (multi_mode ? rec_count : ATS_REC_MIN);
      rec_ptr    <= start_rec;
    end
    else if (stop_req && !map_active)
    begin
      st <= ATS_ST_IDLE;
    end
    else
    begin
      case (st)
        ATS_ST_IDLE: st <= ATS_ST_IDLE;
        ATS_ST_ARMED:
        begin
          dly_cnt <= 32'h0000_0000;
          if (trig_accept)
            st <= ATS_ST_DELAY;
        end
        ATS_ST_DELAY:
        begin
          // storage starts when the delay count is reached
          if (dly_cnt >= dly_target)
            st <= ATS_ST_STORE;
          else
            dly_cnt <= dly_cnt + 32'h0000_0001;
        end
        ATS_ST_STORE:
        begin
          if (capture_done_in)
          begin
            if (!last_rec)
            begin
              remaining <= remaining - 5'h01;
              rec_ptr   <= rec_ptr + 4'h1;
              st        <= ATS_ST_ARMED;
            end
            else if (stop_after_fill || map_active)
            begin
              st         <= ATS_ST_IDLE;
              map_active <= 1'b0;
            end
            else
            begin
              // continuous: refill the same set of records
              remaining <= multi_mode ? rec_count : ATS_REC_MIN;
              rec_ptr   <= start_rec;
              st        <= ATS_ST_ARMED;
            end
          end
        end
        default: st <= ATS_ST_IDLE;
      endcase
    end
  end

  // one-cycle storage start pulse on entering store
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      store_start_out <= 1'b0;
    else
      store_start_out <= (st == ATS_ST_DELAY) && (dly_cnt >= dly_target)
                         && !start_req && !(stop_req && !map_active);
  end

  // registered status outputs
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      acq_state_out    <= ATS_RPT_STOPPED;
      record_ptr_out   <= 4'h0;
      geom_correct_out <= 1'b0;
      map_active_out   <= 1'b0;
    end
    else
    begin
      if (st == ATS_ST_IDLE)
        acq_state_out <= ATS_RPT_STOPPED;
      else if (stop_after_fill)
        acq_state_out <= ATS_RPT_RUN_HALT;
      else
        acq_state_out <= ATS_RPT_RUNNING;
      record_ptr_out   <= rec_ptr;
      geom_correct_out <= geom_en;
      map_active_out   <= map_active;
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      prdata_out <= 32'h0000_0000;
    else if (rd_en)
    begin
      case (paddr_in)
        ATS_OFF_CTRL:   prdata_out <= {27'h000_0000, geom_en, ext_arm_sel,
                                       auto_mode, multi_mode,
                                       stop_after_fill};
        ATS_OFF_RECORD: prdata_out <= {20'h0_0000, start_rec, 3'h0,
                                       rec_count};
        ATS_OFF_TRIG:   prdata_out <= {11'h000, trig_cfg_out};
        ATS_OFF_DELAY:  prdata_out <= {19'h0_0000, post_trigger_delay};
        ATS_OFF_WINDOW: prdata_out <= window_cyc;
        ATS_OFF_STATUS: prdata_out <= {16'h0000, remaining, rec_ptr,
                                       st, map_active, acq_state_out};
        default:        prdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // checks
  a_count_range: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    rec_count >= ATS_REC_MIN && rec_count <= ATS_REC_MAX)
    else $error("record count out of range");
  a_wrap_to_one: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    (st == ATS_ST_STORE && capture_done_in && !last_rec && !start_req
     && !(stop_req && !map_active) && rec_ptr == ATS_PTR_LAST)
    |=> rec_ptr == 4'h0 && st == ATS_ST_ARMED)
    else $error("pointer did not wrap to first record");
  a_ascend_fill: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    (st == ATS_ST_STORE && capture_done_in && !last_rec && !start_req
     && !(stop_req && !map_active))
    |=> rec_ptr == $past(rec_ptr) + 4'h1
        && remaining == $past(remaining) - 5'h01)
    else $error("record pointer did not advance");
  a_halt_after: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    (st == ATS_ST_STORE && capture_done_in && last_rec && stop_after_fill
     && !start_req) |=> st == ATS_ST_IDLE ##1 acq_state_out == ATS_RPT_STOPPED)
    else $error("acquisition did not halt after last record");
  a_no_trig_idle: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    st == ATS_ST_IDLE |=> st != ATS_ST_DELAY && !store_start_out)
    else $error("trigger accepted while stopped");
  a_continuous: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    (st == ATS_ST_STORE && capture_done_in && last_rec && !stop_after_fill
     && !map_active && !start_req && !stop_req)
    |=> st == ATS_ST_ARMED && rec_ptr == $past(start_rec))
    else $error("continuous acquisition did not re-arm");
  a_auto_timeout: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    (st == ATS_ST_ARMED && auto_mode && !start_req && !stop_req
     && auto_cnt == AUTO_TIMEOUT_CYC - 32'h0000_0001)
    |=> st == ATS_ST_DELAY && auto_cnt == 32'h0000_0000)
    else $error("auto trigger did not fire at timeout");
  a_ext_ac: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    (DUAL_CHANNEL && trig_cfg.source == ATS_SRC_EXT)
    |-> trig_cfg_out.coupling == ATS_COUP_AC)
    else $error("external source not ac coupled");
  a_arm_block: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in)
    (st == ATS_ST_ARMED && ext_arm_sel && !auto_mode && ext_arm_n_in
     && !start_req) |=> st != ATS_ST_DELAY)
    else $error("trigger accepted while external arm high");

endmodule : ats_sequencer
`default_nettype wire

// ==== sim/ats_capture_model.sv ====
/*
  capture engine stand-in: answers each store start with one done pulse
  a fixed fill time later. assumes the sequencer's clock and reset.
*/
`default_nettype none
module ats_capture_model
  import ats_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // sequencer side
  input  wire logic store_start_in,
  output logic      capture_done_out
);
  logic [3:0] fill_cnt; // cycles left in the current fill
  // count the fill time down, then report the record filled
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      fill_cnt         <= 4'h0;
      capture_done_out <= 1'b0;
    end
    else
    begin
      capture_done_out <= (fill_cnt == 4'h1);
      if (store_start_in)
        fill_cnt <= 4'h5;
      else if (fill_cnt != 4'h0)
        fill_cnt <= fill_cnt - 4'h1;
    end
  end
endmodule : ats_capture_model
`default_nettype wire

// ==== sim/tb_acquisition_trigger_sequencer.sv ====
/*
  self-checking bench for the sequencer: apb master tasks, one task per
  scenario. assumes the capture model answers every store start.
*/
`default_nettype none
module tb_acquisition_trigger_sequencer
  import ats_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, perr, hit;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic ch1 = 0, ch2 = 0, sum = 0, ext = 0, cal = 0, inv = 0, arm_n = 1;
  logic mtrig = 0, mstop = 0, done, sst, geom, map;
  logic [3:0] ptr;
  logic [1:0] st;
  ats_trig_cfg_s cfg;
  int fails = 0, checks = 0, n;
  // 20 MHz core clock
  always #25 clk = ~clk;
  ats_sequencer #(.AUTO_TIMEOUT_CYC(50), .DUAL_CHANNEL(1'b1), .MAP_ACQS(8))
  dut (.core_clk_in(clk), .sys_rst_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .channel_one_input_in(ch1),
    .channel_two_input_in(ch2), .channel_sum_in(sum), .ext_trig_in(ext),
    .calib_in(cal), .ch_invert_in(inv), .ext_arm_n_in(arm_n),
    .trig_cfg_out(cfg), .man_trig_in(mtrig), .man_stop_in(mstop),
    .capture_done_in(done), .store_start_out(sst), .record_ptr_out(ptr),
    .geom_correct_out(geom), .map_active_out(map), .acq_state_out(st));
  ats_capture_model cap (.clk_in(clk), .rst_in(rst),
    .store_start_in(sst), .capture_done_out(done));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // only the watchdog ends a wait that never sees pready high
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    hit = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // wait at most lim cycles for a store start, n counts the cycles
  task automatic wstore(input int lim);
    hit = 0;
    for (n = 1; n <= lim && !hit; n++)
    begin
      @(negedge clk);
      hit = (sst === 1'b1);
    end
    repeat (10) @(posedge clk);
  endtask : wstore
  task automatic tpulse();
    @(posedge clk);
    mtrig <= 1'b1;
    @(posedge clk);
    mtrig <= 1'b0;
  endtask : tpulse
  task automatic t_defaults();
    apb(0, ATS_OFF_CTRL, 0);
    chk(rdat, 32'h0000_0004);
    apb(0, ATS_OFF_RECORD, 0);
    chk(rdat, 32'h0000_0001);
    apb(1, ATS_OFF_RECORD, 32'h0000_0011);
    apb(0, ATS_OFF_RECORD, 0);
    chk(rdat, 32'h0000_0001);
    apb(0, 8'h1C, 0);
    chk(hit, 1'b1);
    chk(rdat, 32'h0000_0000);
    apb(1, ATS_OFF_CTRL, 32'h0000_0014);
    // enable reaches the registered output one edge after the write
    repeat (2) @(posedge clk);
    chk(geom, 1'b1);
  endtask : t_defaults
  // records 15, 16, 1 then halt; later triggers ignored
  task automatic t_wrap();
    int e[3] = '{14, 15, 0};
    apb(1, ATS_OFF_CTRL, 32'h0000_0003);
    apb(1, ATS_OFF_RECORD, 32'h0000_0E03);
    apb(1, ATS_OFF_CMD, 32'h0000_0006);
    repeat (2) @(posedge clk);
    chk(st, ATS_RPT_RUN_HALT);
    for (int i = 0; i < 3; i++)
    begin
      chk(ptr, e[i][3:0]);
      tpulse();
      wstore(20);
      chk(hit, 1'b1);
    end
    chk(st, ATS_RPT_STOPPED);
    apb(0, ATS_OFF_CTRL, 0);
    chk(rdat[0], 1'b1);
    tpulse();
    wstore(20);
    chk(hit, 1'b0);
  endtask : t_wrap
  task automatic t_auto();
    apb(1, ATS_OFF_CTRL, 32'h0000_0005);
    apb(1, ATS_OFF_RECORD, 32'h0000_0001);
    apb(1, ATS_OFF_CMD, 32'h0000_0006);
    wstore(80);
    chk({hit, n >= 45 && n <= 60}, 2'b11);
  endtask : t_auto
  task automatic t_arm();
    apb(1, ATS_OFF_CTRL, 32'h0000_0009);
    apb(1, ATS_OFF_CMD, 32'h0000_0006);
    tpulse();
    wstore(80);
    chk(hit, 1'b0);
    arm_n <= 1'b0;
    tpulse();
    wstore(20);
    chk(hit, 1'b1);
    arm_n <= 1'b1;
    apb(1, ATS_OFF_CTRL, 32'h0000_000D);
    apb(1, ATS_OFF_CMD, 32'h0000_0006);
    wstore(80);
    chk(hit, 1'b1);
  endtask : t_arm
  task automatic t_slope();
    apb(1, ATS_OFF_TRIG, 32'h0000_001B);
    @(posedge clk);
    chk(cfg.coupling, ATS_COUP_AC);
    chk(cfg.pct_units, 1'b0);
    apb(1, ATS_OFF_CTRL, 32'h0000_0001);
    apb(1, ATS_OFF_TRIG, 32'h0000_0004);
    apb(1, ATS_OFF_CMD, 32'h0000_0006);
    ch1 <= 1'b1;
    wstore(10);
    chk(hit, 1'b0);
    ch1 <= 1'b0;
    wstore(10);
    chk(hit, 1'b1);
  endtask : t_slope
  // mapping run: eight records, stop ignored, then stopped
  task automatic t_map();
    apb(1, ATS_OFF_CTRL, 32'h0000_0004);
    apb(1, ATS_OFF_CMD, 32'h0000_0010);
    apb(1, ATS_OFF_CMD, 32'h0000_0004);
    apb(0, ATS_OFF_STATUS, 0);
    chk(rdat[15:11], 5'h08);
    chk({map, st}, {1'b1, ATS_RPT_RUNNING});
    for (int i = 0; i < 8; i++)
    begin
      wstore(80);
      chk(hit, 1'b1);
    end
    chk({map, st}, {1'b0, ATS_RPT_STOPPED});
  endtask : t_map
  task automatic t_cont();
    apb(1, ATS_OFF_CTRL, 32'h0000_0000);
    apb(1, ATS_OFF_CMD, 32'h0000_0005);
    tpulse();
    wstore(20);
    chk({hit, st}, {1'b1, ATS_RPT_RUNNING});
    apb(1, ATS_OFF_DELAY, 32'h0000_1FFF);
    apb(0, ATS_OFF_DELAY, 0);
    chk(rdat, {19'h0_0000, ATS_DLY_MAX});
    // four windows of ten cycles, window set after the delay
    apb(1, ATS_OFF_DELAY, 32'h0000_1000);
    apb(1, ATS_OFF_WINDOW, 32'h0000_000A);
    apb(1, ATS_OFF_CMD, 32'h0000_0008);
    wstore(60);
    // 40 delay cycles plus accept and pulse latency
    chk({hit, n == 43}, 2'b11);
    @(posedge clk);
    mstop <= 1'b1;
    @(posedge clk);
    mstop <= 1'b0;
    repeat (3) @(posedge clk);
    chk(st, ATS_RPT_STOPPED);
  endtask : t_cont
  task automatic test_done();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_wrap();
    t_auto();
    t_arm();
    t_slope();
    t_map();
    t_cont();
    test_done();
  end
  // watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule : tb_acquisition_trigger_sequencer
`default_nettype wire
